// File: inc/accel_regs_pkg.sv
// Register map, fields and codes of the register group.
// Assumes an 8-bit address space reached by a serial engine.
package accel_regs_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_PAD_CTRL = 8'h22;
  localparam logic [7:0] ADDR_FMT_CTRL = 8'h23;
  localparam logic [7:0] ADDR_WAKE_CTRL = 8'h24;
  localparam logic [7:0] ADDR_FILTER_ZERO = 8'h25;
  localparam logic [7:0] ADDR_BASELINE = 8'h26;
  localparam logic [7:0] ADDR_STATUS = 8'h27;
  localparam logic [7:0] ADDR_OUT_X_LO = 8'h28;
  localparam logic [7:0] ADDR_OUT_Z_HI = 8'h2d;
  localparam logic [7:0] ADDR_IRQ1_SRC = 8'h31;
  localparam logic [7:0] ADDR_IRQ2_SRC = 8'h35;

  // Reset values
  localparam logic [7:0] PAD_CTRL_RST = 8'h00;
  localparam logic [7:0] FMT_CTRL_RST = 8'h00;
  localparam logic [7:0] WAKE_CTRL_RST = 8'h00;
  localparam logic [7:0] BASELINE_RST = 8'h00;

  // Writable bits; the rest read as zero
  localparam logic [7:0] PAD_CTRL_WMASK = 8'hff;
  localparam logic [7:0] FMT_CTRL_WMASK = 8'hf9;
  localparam logic [7:0] WAKE_CTRL_WMASK = 8'h03;

  // Interrupt pad control fields
  localparam int PAD_POL_BIT = 7;
  localparam int PAD_DRIVE_BIT = 6;
  localparam int PAD_LATCH2_BIT = 5;
  localparam int PAD_ROUTE2_LSB = 3;
  localparam int PAD_LATCH1_BIT = 2;
  localparam int PAD_ROUTE1_LSB = 0;

  // Output format control fields
  localparam int FMT_HOLD_BIT = 7;
  localparam int FMT_ORDER_BIT = 6;
  localparam int FMT_RANGE_LSB = 4;
  localparam int FMT_DIAG_POL_BIT = 3;
  localparam int FMT_DIAG_EN_BIT = 0;

  // Sleep-to-wake field
  localparam int WAKE_FUNC_LSB = 0;
  localparam logic [1:0] WAKE_FUNC_ON = 2'b11;

  // Pad route codes
  localparam logic [1:0] ROUTE_OWN = 2'b00;
  localparam logic [1:0] ROUTE_EITHER = 2'b01;
  localparam logic [1:0] ROUTE_DRDY = 2'b10;
  localparam logic [1:0] ROUTE_BOOT = 2'b11;

  // Full-scale codes (2'b10 is undefined and passed through)
  localparam logic [1:0] RANGE_2G = 2'b00;
  localparam logic [1:0] RANGE_4G = 2'b01;
  localparam logic [1:0] RANGE_8G = 2'b11;

  // Power mode codes
  localparam logic [2:0] PM_DOWN = 3'b000;
  localparam logic [2:0] PM_NORMAL = 3'b001;
  localparam logic [2:0] PM_LP_FIRST = 3'b010;
  localparam logic [2:0] PM_LP_LAST = 3'b110;

  // High-pass filter mode using the baseline value
  localparam logic [1:0] HPF_MODE_REF = 2'b01;

  // Interrupt source: event bit count
  localparam int SRC_EVENTS = 6;

endpackage

// File: inc/axis_link_if.sv
// Link from the register group to one axis stage.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface axis_link_if #(parameter int W = 16);
  logic load;
  logic [W-1:0] sample;
  logic zero;
  logic rd_lo;
  logic rd_hi;
  logic hold_en;
  logic msb_first;
  logic [W/2-1:0] byte_lo;
  logic [W/2-1:0] byte_hi;
  logic ready;
  logic overrun;

  modport stage (input load, sample, zero, rd_lo, rd_hi, hold_en,
    msb_first, output byte_lo, byte_hi, ready, overrun);
  modport ctrl (output load, sample, zero, rd_lo, rd_hi, hold_en,
    msb_first, input byte_lo, byte_hi, ready, overrun);
endinterface

// File: hdl/axis_output_stage.sv
// One axis output word: pairing hold, byte order, data flags.
// Assumes one-cycle read strobes on the register clock.
`timescale 1ns/1ps
module axis_output_stage
  #(parameter int W = 16)
  (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Link to the register group
  axis_link_if.stage lnk
  );

  logic [W-1:0] word_q;
  logic hold_q;
  logic first_hi_q;
  logic ready_q;
  logic overrun_q;
  logic rd_any;
  logic release_now;
  logic freeze;

  // A hold ends when the other half of the pair is read or hold_en drops
  assign rd_any = lnk.rd_lo | lnk.rd_hi;
  assign release_now = hold_q & (first_hi_q ? lnk.rd_lo : lnk.rd_hi);
  assign freeze = lnk.hold_en & (hold_q ? ~release_now : rd_any);

  // Pairing hold tracking
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      hold_q <= 1'b0;
      first_hi_q <= 1'b0;
    end
    else if (!lnk.hold_en || release_now)
      hold_q <= 1'b0;
    else if (!hold_q && rd_any)
    begin
      hold_q <= 1'b1;
      first_hi_q <= lnk.rd_hi;
    end

  // Output word: zeroing wins, a frozen word drops new samples
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      word_q <= '0;
    else if (lnk.zero)
      word_q <= '0;
    else if (lnk.load && !freeze)
      word_q <= lnk.sample;

  // Flags: a new sample wins over a read in the same cycle
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      ready_q <= 1'b0;
      overrun_q <= 1'b0;
    end
    else
    begin
      ready_q <= lnk.load | (ready_q & ~rd_any);
      overrun_q <= (lnk.load & ready_q) | (overrun_q & ~rd_any);
    end

  // Byte placement by address
  assign lnk.byte_lo = lnk.msb_first ? word_q[W-1:W/2] : word_q[W/2-1:0];
  assign lnk.byte_hi = lnk.msb_first ? word_q[W/2-1:0] : word_q[W-1:W/2];
  assign lnk.ready = ready_q;
  assign lnk.overrun = overrun_q;

endmodule // axis_output_stage

// File: hdl/accel_ctrl_status_regs.sv
// Control and status register group: pad control, output
// format, sleep-to-wake, filter baseline and sample status.
// Assumes one-cycle read and write strobes with an 8-bit address
// and a sensor core on this clock.
//
// Summary of operation
// - Pad polarity bit: 0 high, 1 low.
// - Pad drive bit: 0 push-pull, 1 open-drain.
// - Interrupt-2 latch holds source until read.
// - Interrupt-1 latch holds source until read.
// - Route field picks own, OR, ready, boot.
// - Block-update holds output until pair read.
// - Byte order bit swaps bytes per address.
// - Range field selects 2, 4, 8 g.
// - Self-test sign bit picks stimulus polarity.
// - Self-test enable bit switches self-test.
// - Wake field 11 enables sleep-to-wake.
// - Interrupt wakes to normal; settings unchanged.
// - Filter-reset read zeroes filter (not in mode 01) and filtered outputs.
// - Baseline value used in reference mode.
// - New-data flags per axis and set.
// - Overrun flags per axis and set.
// - Power mode field decodes down/normal/low-power.
// - Mode 01 reference, others normal filtering.
// - Source read clears active flag and pad.
`timescale 1ns/1ps
module accel_ctrl_status_regs
  import accel_regs_pkg::*;
  #(parameter int W = 16)
  (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register access from the serial engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Settings held in neighbouring registers
  input wire logic [2:0] power_mode_field,
  input wire logic [1:0] hpf_mode_field,
  input wire logic filtered_output_select,
  input wire logic hpf_on_irq1,
  input wire logic hpf_on_irq2,
  // Sensor core events and samples
  input wire logic boot_running,
  input wire logic [SRC_EVENTS-1:0] irq1_events,
  input wire logic [SRC_EVENTS-1:0] irq2_events,
  input wire logic [2:0] sample_valid,
  input wire logic [W-1:0] sample_x,
  input wire logic [W-1:0] sample_y,
  input wire logic [W-1:0] sample_z,
  // Interrupt pads
  output logic irq1_pad_o,
  output logic irq1_pad_oe_b,
  output logic irq2_pad_o,
  output logic irq2_pad_oe_b,
  // Controls to the sensor core
  output logic [1:0] range_select,
  output logic diag_enable,
  output logic diag_polarity,
  output logic run_power_down,
  output logic run_normal,
  output logic run_low_power,
  output logic [2:0] low_power_rate,
  output logic [7:0] hpf_baseline_bits,
  output logic hpf_reference_mode,
  output logic hpf_state_clear
  );

  // Latched sources gather until read, plain ones follow events;
  // a read never loses a fresh event.
  function automatic logic [SRC_EVENTS-1:0] src_next(
    input logic [SRC_EVENTS-1:0] cur,
    input logic [SRC_EVENTS-1:0] ev,
    input logic latch,
    input logic rd);
    if (latch && !rd)
      src_next = cur | ev;
    else
      src_next = ev;
  endfunction

  // Pad signal selection by route code
  function automatic logic route_sel(
    input logic [1:0] code,
    input logic own,
    input logic other,
    input logic drdy,
    input logic boot);
    unique case (code)
      ROUTE_OWN: route_sel = own;
      ROUTE_EITHER: route_sel = own | other;
      ROUTE_DRDY: route_sel = drdy;
      ROUTE_BOOT: route_sel = boot;
    endcase
  endfunction

  logic [7:0] pad_ctrl_q;
  logic [7:0] fmt_ctrl_q;
  logic [7:0] wake_ctrl_q;
  logic [7:0] baseline_q;
  logic [SRC_EVENTS-1:0] src1_q;
  logic [SRC_EVENTS-1:0] src2_q;
  logic ia1_q;
  logic ia2_q;
  logic awake_q;
  logic [7:0] reg_rdata_q;
  logic irq1_pad_o_q;
  logic irq1_pad_oe_b_q;
  logic irq2_pad_o_q;
  logic irq2_pad_oe_b_q;
  logic run_power_down_q;
  logic run_normal_q;
  logic run_low_power_q;
  logic hpf_reference_mode_q;
  logic hpf_state_clear_q;
  logic [2:0] low_power_rate_q;

  logic rd_src1;
  logic rd_src2;
  logic rd_zero;
  logic [SRC_EVENTS-1:0] src1_d;
  logic [SRC_EVENTS-1:0] src2_d;
  logic set_ready;
  logic set_overrun;
  logic pad1_sig;
  logic pad2_sig;
  logic wake_func;
  logic pm_low_power;
  logic [2:0] ready_v;
  logic [2:0] overrun_v;
  logic [W/2-1:0] byte_lo_v [3];
  logic [W/2-1:0] byte_hi_v [3];
  logic [W-1:0] sample_v [3];

  // Read strobes with side effects
  assign rd_src1 = reg_rd & (reg_addr == ADDR_IRQ1_SRC);
  assign rd_src2 = reg_rd & (reg_addr == ADDR_IRQ2_SRC);
  assign rd_zero = reg_rd & (reg_addr == ADDR_FILTER_ZERO);

  // Writable registers; read-only addresses take no write
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      pad_ctrl_q <= PAD_CTRL_RST;
      fmt_ctrl_q <= FMT_CTRL_RST;
      wake_ctrl_q <= WAKE_CTRL_RST;
      baseline_q <= BASELINE_RST;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        ADDR_PAD_CTRL: pad_ctrl_q <= reg_wdata & PAD_CTRL_WMASK;
        ADDR_FMT_CTRL: fmt_ctrl_q <= reg_wdata & FMT_CTRL_WMASK;
        ADDR_WAKE_CTRL: wake_ctrl_q <= reg_wdata & WAKE_CTRL_WMASK;
        ADDR_BASELINE: baseline_q <= reg_wdata;
        default: ;
      endcase
    end

  // Source registers and active flags
  assign src1_d = src_next(src1_q, irq1_events,
    pad_ctrl_q[PAD_LATCH1_BIT], rd_src1);
  assign src2_d = src_next(src2_q, irq2_events,
    pad_ctrl_q[PAD_LATCH2_BIT], rd_src2);

  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      src1_q <= '0;
      src2_q <= '0;
      ia1_q <= 1'b0;
      ia2_q <= 1'b0;
    end
    else
    begin
      src1_q <= src1_d;
      src2_q <= src2_d;
      ia1_q <= |src1_d;
      ia2_q <= |src2_d;
    end

  // One output stage per axis
  assign sample_v[0] = sample_x;
  assign sample_v[1] = sample_y;
  assign sample_v[2] = sample_z;

  for (genvar i = 0; i < 3; i++)
  begin : g_axis
    axis_link_if #(.W(W)) lnk ();
    localparam logic [7:0] LO_ADDR = ADDR_OUT_X_LO + 8'(2 * i);
    localparam logic [7:0] HI_ADDR = ADDR_OUT_X_LO + 8'(2 * i + 1);

    assign lnk.load = sample_valid[i];
    assign lnk.sample = sample_v[i];
    // Filtered outputs drop to zero at once on a filter reset read
    assign lnk.zero = rd_zero & filtered_output_select;
    assign lnk.rd_lo = reg_rd & (reg_addr == LO_ADDR);
    assign lnk.rd_hi = reg_rd & (reg_addr == HI_ADDR);
    assign lnk.hold_en = fmt_ctrl_q[FMT_HOLD_BIT];
    assign lnk.msb_first = fmt_ctrl_q[FMT_ORDER_BIT];
    assign byte_lo_v[i] = lnk.byte_lo;
    assign byte_hi_v[i] = lnk.byte_hi;
    assign ready_v[i] = lnk.ready;
    assign overrun_v[i] = lnk.overrun;

    axis_output_stage #(.W(W)) u_stage (
      .clock(clock),
      .rst_b(rst_b),
      .lnk(lnk.stage)
    );
  end

  // Set flags summarise the three axes
  assign set_ready = &ready_v;
  assign set_overrun = |overrun_v;

  // Registered read data; reserved bits read zero
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      reg_rdata_q <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_PAD_CTRL: reg_rdata_q <= pad_ctrl_q;
        ADDR_FMT_CTRL: reg_rdata_q <= fmt_ctrl_q;
        ADDR_WAKE_CTRL: reg_rdata_q <= wake_ctrl_q;
        ADDR_BASELINE: reg_rdata_q <= baseline_q;
        ADDR_STATUS: reg_rdata_q <= {set_overrun, overrun_v[2],
          overrun_v[1], overrun_v[0], set_ready, ready_v};
        ADDR_IRQ1_SRC: reg_rdata_q <= {1'b0, ia1_q, src1_q};
        ADDR_IRQ2_SRC: reg_rdata_q <= {1'b0, ia2_q, src2_q};
        ADDR_OUT_X_LO: reg_rdata_q <= byte_lo_v[0];
        ADDR_OUT_X_LO + 8'h01: reg_rdata_q <= byte_hi_v[0];
        ADDR_OUT_X_LO + 8'h02: reg_rdata_q <= byte_lo_v[1];
        ADDR_OUT_X_LO + 8'h03: reg_rdata_q <= byte_hi_v[1];
        ADDR_OUT_X_LO + 8'h04: reg_rdata_q <= byte_lo_v[2];
        ADDR_OUT_Z_HI: reg_rdata_q <= byte_hi_v[2];
        default: reg_rdata_q <= 8'h00;
      endcase
    end

  // Pad signal by route code
  assign pad1_sig = route_sel(pad_ctrl_q[PAD_ROUTE1_LSB +: 2], ia1_q,
    ia2_q, set_ready, boot_running);
  assign pad2_sig = route_sel(pad_ctrl_q[PAD_ROUTE2_LSB +: 2], ia2_q,
    ia1_q, set_ready, boot_running);

  // Open drain only pulls low and floats otherwise:
  // a pull-up must sit outside.
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      irq1_pad_o_q <= 1'b0;
      irq1_pad_oe_b_q <= 1'b0;
      irq2_pad_o_q <= 1'b0;
      irq2_pad_oe_b_q <= 1'b0;
    end
    else if (pad_ctrl_q[PAD_DRIVE_BIT])
    begin
      irq1_pad_o_q <= 1'b0;
      irq1_pad_oe_b_q <= pad1_sig ^ pad_ctrl_q[PAD_POL_BIT];
      irq2_pad_o_q <= 1'b0;
      irq2_pad_oe_b_q <= pad2_sig ^ pad_ctrl_q[PAD_POL_BIT];
    end
    else
    begin
      irq1_pad_o_q <= pad1_sig ^ pad_ctrl_q[PAD_POL_BIT];
      irq1_pad_oe_b_q <= 1'b0;
      irq2_pad_o_q <= pad2_sig ^ pad_ctrl_q[PAD_POL_BIT];
      irq2_pad_oe_b_q <= 1'b0;
    end

  // Sleep-to-wake: an interrupt lifts low power to normal rate
  // but leaves the stored power mode alone; awake lasts until
  // the function or low power is dropped.
  assign wake_func = wake_ctrl_q[WAKE_FUNC_LSB +: 2] == WAKE_FUNC_ON;
  assign pm_low_power = (power_mode_field >= PM_LP_FIRST) &&
    (power_mode_field <= PM_LP_LAST);

  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      awake_q <= 1'b0;
    else if (!wake_func || !pm_low_power)
      awake_q <= 1'b0;
    else if (ia1_q || ia2_q)
      awake_q <= 1'b1;

  // Power mode decode for the core
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      run_power_down_q <= 1'b1;
      run_normal_q <= 1'b0;
      run_low_power_q <= 1'b0;
      low_power_rate_q <= PM_DOWN;
    end
    else
    begin
      run_power_down_q <= power_mode_field == PM_DOWN;
      run_normal_q <= (power_mode_field == PM_NORMAL) ||
        (pm_low_power && awake_q);
      run_low_power_q <= pm_low_power && !awake_q;
      low_power_rate_q <= power_mode_field;
    end

  // Reference mode needs a filter enable; the state clear
  // pulses one cycle after the reset address is read.
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      hpf_reference_mode_q <= 1'b0;
      hpf_state_clear_q <= 1'b0;
    end
    else
    begin
      hpf_reference_mode_q <= (filtered_output_select | hpf_on_irq1 |
        hpf_on_irq2) & (hpf_mode_field == HPF_MODE_REF);
      hpf_state_clear_q <= rd_zero &&
        (hpf_mode_field != HPF_MODE_REF);
    end

  // Outputs straight from flip-flops
  assign reg_rdata = reg_rdata_q;
  assign irq1_pad_o = irq1_pad_o_q;
  assign irq1_pad_oe_b = irq1_pad_oe_b_q;
  assign irq2_pad_o = irq2_pad_o_q;
  assign irq2_pad_oe_b = irq2_pad_oe_b_q;
  assign range_select = fmt_ctrl_q[FMT_RANGE_LSB +: 2];
  assign diag_enable = fmt_ctrl_q[FMT_DIAG_EN_BIT];
  assign diag_polarity = fmt_ctrl_q[FMT_DIAG_POL_BIT];
  assign run_power_down = run_power_down_q;
  assign run_normal = run_normal_q;
  assign run_low_power = run_low_power_q;
  assign low_power_rate = low_power_rate_q;
  assign hpf_baseline_bits = baseline_q;
  assign hpf_reference_mode = hpf_reference_mode_q;
  assign hpf_state_clear = hpf_state_clear_q;

endmodule // accel_ctrl_status_regs

// File: sim/accel_ctrl_status_regs_props.sv
// Port-level assertions for the register group.
// Assumes one clock; shadows rebuilt from writes.
`timescale 1ns/1ps
module accel_ctrl_status_regs_props
  import accel_regs_pkg::*;
  (
  // Clock and reset
  input logic clock,
  input logic rst_b,
  // Register access
  input logic [7:0] reg_addr,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_wdata,
  // Neighbouring settings and events
  input logic [2:0] power_mode_field,
  input logic [1:0] hpf_mode_field,
  input logic filtered_output_select,
  input logic hpf_on_irq1,
  input logic hpf_on_irq2,
  input logic boot_running,
  input logic [SRC_EVENTS-1:0] irq1_events,
  // Watched outputs
  input logic irq1_pad_o,
  input logic irq1_pad_oe_b,
  input logic irq2_pad_o,
  input logic irq2_pad_oe_b,
  input logic [1:0] range_select,
  input logic diag_enable,
  input logic diag_polarity,
  input logic run_power_down,
  input logic run_normal,
  input logic run_low_power,
  input logic [7:0] hpf_baseline_bits,
  input logic hpf_reference_mode,
  input logic hpf_state_clear
  );
  logic [7:0] pad_q;
  logic [7:0] fmt_q;
  logic [1:0] wake_q;
  logic lvl;
  logic keep1;
  // Shadows take writes at the block's edge
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      pad_q <= 8'h00;
      fmt_q <= 8'h00;
      wake_q <= 2'h0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_PAD_CTRL) pad_q <= reg_wdata;
      if (reg_addr == ADDR_FMT_CTRL) fmt_q <= reg_wdata & FMT_CTRL_WMASK;
      if (reg_addr == ADDR_WAKE_CTRL) wake_q <= reg_wdata[1:0];
    end
  // Pad level; latched window without bus traffic
  assign lvl = boot_running ^ pad_q[PAD_POL_BIT];
  assign keep1 = pad_q[2] && pad_q[1:0] == ROUTE_OWN && !pad_q[6] &&
    !reg_rd && !reg_wr;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  property p_fmt;
    range_select == fmt_q[5:4] && diag_polarity == fmt_q[3] &&
      diag_enable == fmt_q[0];
  endproperty
  a_fmt: assert property (p_fmt)
    else $error("format outputs wrong");
  property p_base;
    (reg_wr && reg_addr == ADDR_BASELINE) |=>
      hpf_baseline_bits == $past(reg_wdata);
  endproperty
  a_base: assert property (p_base)
    else $error("baseline wrong");
  property p_ref;
    1'b1 |=> hpf_reference_mode == ($past(hpf_mode_field) == HPF_MODE_REF
      && ($past(filtered_output_select) || $past(hpf_on_irq1) ||
      $past(hpf_on_irq2)));
  endproperty
  a_ref: assert property (p_ref)
    else $error("reference mode wrong");
  property p_clear;
    (reg_rd && reg_addr == ADDR_FILTER_ZERO &&
      hpf_mode_field != HPF_MODE_REF) |=> hpf_state_clear;
  endproperty
  a_clear: assert property (p_clear)
    else $error("filter clear pulse missing");
  property p_norm;
    (power_mode_field == PM_NORMAL)[*2] |=>
      run_normal && !run_low_power && !run_power_down;
  endproperty
  a_norm: assert property (p_norm)
    else $error("normal mode wrong");
  property p_lp;
    (power_mode_field >= PM_LP_FIRST && power_mode_field <= PM_LP_LAST &&
      wake_q != WAKE_FUNC_ON)[*2] |=> run_low_power && !run_normal;
  endproperty
  a_lp: assert property (p_lp)
    else $error("low-power mode wrong");
  property p_boot;
    (pad_q[1:0] == ROUTE_BOOT && !pad_q[PAD_DRIVE_BIT]) |=>
      irq1_pad_o == $past(lvl) && !irq1_pad_oe_b;
  endproperty
  a_boot: assert property (p_boot)
    else $error("pad one wrong");
  property p_od;
    (pad_q[4:3] == ROUTE_BOOT && pad_q[PAD_DRIVE_BIT]) |=>
      !irq2_pad_o && irq2_pad_oe_b == $past(lvl);
  endproperty
  a_od: assert property (p_od)
    else $error("pad two wrong");
  property p_latch;
    (keep1 && irq1_events != 6'h00) ##1 keep1[*3] |->
      irq1_pad_o != pad_q[PAD_POL_BIT];
  endproperty
  a_latch: assert property (p_latch)
    else $error("latch lost");
  c_clear: cover property (reg_rd && reg_addr == ADDR_FILTER_ZERO);
  c_latch: cover property (keep1 && irq1_events != 6'h00);
  c_wake: cover property (run_normal && power_mode_field == PM_LP_FIRST);
endmodule // accel_ctrl_status_regs_props
bind accel_ctrl_status_regs accel_ctrl_status_regs_props props_inst (
  .clock, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
  .power_mode_field, .hpf_mode_field, .filtered_output_select,
  .hpf_on_irq1, .hpf_on_irq2, .boot_running, .irq1_events, .irq1_pad_o,
  .irq1_pad_oe_b, .irq2_pad_o, .irq2_pad_oe_b, .range_select,
  .diag_enable, .diag_polarity, .run_power_down, .run_normal,
  .run_low_power, .hpf_baseline_bits, .hpf_reference_mode,
  .hpf_state_clear);

// File: sim/host_model.sv
// Host model: register reads and writes on the strobe bus.
// Assumes the block takes a request on a rising edge with its strobe.
`timescale 1ns/1ps
module host_model
  (
  // Clock
  input logic clock,
  // Register bus
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata
  );
  // Idle bus at time zero
  initial
    {reg_addr, reg_wr, reg_rd, reg_wdata} = 18'h00000;
  // One write; released lines show the inverse
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~w;
  endtask
  // One read; data taken the edge after acceptance
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clock);
    r = reg_rdata;
  endtask
endmodule // host_model

// File: sim/tb.sv
// Self-checking bench for the register group.
// Assumes the host model drives the register strobes.
`timescale 1ns/1ps
module tb
  import accel_regs_pkg::*;
  ;
  typedef struct {
    logic [7:0] a, w, r;
    logic [2:0] pm;
    logic bt;
    logic [5:0] e1, e2;
    logic o, oe;
  } row_t;
  logic clock, rst_b, reg_wr, reg_rd, boot_running, filtered_output_select;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [2:0] power_mode_field, sample_valid, low_power_rate;
  logic [1:0] hpf_mode_field, range_select;
  logic hpf_on_irq1, diag_enable, diag_polarity, run_power_down;
  logic run_normal, run_low_power, hpf_reference_mode, hpf_state_clear;
  logic irq1_pad_o, irq1_pad_oe_b, irq2_pad_o, irq2_pad_oe_b;
  logic [5:0] irq1_events, irq2_events;
  logic [15:0] smp;
  logic [7:0] hpf_baseline_bits;
  int err_count = 0;
  int checks = 0;
  // Register rows, then pad route and drive rows
  row_t rows [16] = '{
    '{8'h23,8'h10,8'h10,3'h0,1'h0,6'h0,6'h0,1'h0,1'h0},
    '{8'h23,8'h30,8'h30,3'h1,1'h0,6'h0,6'h0,1'h0,1'h0},
    '{8'h23,8'hff,8'hf9,3'h2,1'h0,6'h0,6'h0,1'h0,1'h0},
    '{8'h24,8'hff,8'h03,3'h3,1'h0,6'h0,6'h0,1'h0,1'h0},
    '{8'h24,8'hfc,8'h00,3'h4,1'h0,6'h0,6'h0,1'h0,1'h0},
    '{8'h26,8'h5a,8'h5a,3'h5,1'h0,6'h0,6'h0,1'h0,1'h0},
    '{8'h25,8'hff,8'h00,3'h6,1'h0,6'h0,6'h0,1'h0,1'h0},
    '{8'h27,8'hff,8'h00,3'h1,1'h0,6'h0,6'h0,1'h0,1'h0},
    '{8'h40,8'hff,8'h00,3'h1,1'h0,6'h0,6'h0,1'h0,1'h0},
    '{8'h22,8'h01,8'h01,3'h1,1'h0,6'h0,6'h4,1'h1,1'h0},
    '{8'h22,8'h00,8'h00,3'h1,1'h0,6'h10,6'h0,1'h1,1'h0},
    '{8'h22,8'h03,8'h03,3'h1,1'h1,6'h0,6'h0,1'h1,1'h0},
    '{8'h22,8'h83,8'h83,3'h1,1'h1,6'h0,6'h0,1'h0,1'h0},
    '{8'h22,8'hdb,8'hdb,3'h1,1'h1,6'h0,6'h0,1'h0,1'h0},
    '{8'h22,8'h5b,8'h5b,3'h1,1'h1,6'h0,6'h0,1'h0,1'h1},
    '{8'h22,8'h82,8'h82,3'h1,1'h0,6'h0,6'h0,1'h1,1'h0}};
  host_model host_model_inst (.clock, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata);
  accel_ctrl_status_regs accel_ctrl_status_regs_inst (.clock, .rst_b,
    .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .power_mode_field,
    .hpf_mode_field, .filtered_output_select, .hpf_on_irq1,
    .hpf_on_irq2(1'b0), .boot_running, .irq1_events, .irq2_events,
    .sample_valid, .sample_x(smp), .sample_y(smp), .sample_z(smp),
    .irq1_pad_o, .irq1_pad_oe_b, .irq2_pad_o, .irq2_pad_oe_b,
    .range_select, .diag_enable, .diag_polarity, .run_power_down,
    .run_normal, .run_low_power, .low_power_rate, .hpf_baseline_bits,
    .hpf_reference_mode, .hpf_state_clear);
  // Shared compare, reported at once
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Single end of run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One sample pulse on the chosen axes
  task automatic pulse(input logic [2:0] v, input logic [15:0] w);
    @(posedge clock);
    sample_valid <= v;
    smp <= w;
    @(posedge clock);
    sample_valid <= 3'h0;
  endtask
  // 20 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Watchdog, far past the test length
  initial
  begin
    repeat (6000) @(posedge clock);
    err_count++;
    print_verdict();
  end
  // Main sequence
  initial
  begin
    {rst_b, boot_running, filtered_output_select, hpf_on_irq1} = 4'h0;
    {power_mode_field, hpf_mode_field, sample_valid} = 8'h00;
    {irq1_events, irq2_events, smp} = 28'h0000000;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    foreach (rows[i])
    begin
      @(posedge clock);
      power_mode_field <= rows[i].pm;
      boot_running <= rows[i].bt;
      irq1_events <= rows[i].e1;
      irq2_events <= rows[i].e2;
      host_model_inst.wr(rows[i].a, rows[i].w);
      host_model_inst.rd(rows[i].a, d);
      chk(d, rows[i].r);
      repeat (3) @(posedge clock);
      chk({7'h00, irq1_pad_o}, {7'h00, rows[i].o});
      chk({7'h00, irq1_pad_oe_b}, {7'h00, rows[i].oe});
    end
    $display("test rows done");
    // Mid-run reset restores defaults
    @(posedge clock);
    {rst_b, boot_running} <= 2'h0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    for (int a = 8'h22; a <= 8'h27; a++)
    begin
      host_model_inst.rd(8'(a), d);
      chk(d, 8'h00);
    end
    $display("test reset done");
    pulse(3'h1, 16'h1234);
    host_model_inst.rd(ADDR_STATUS, d);
    chk(d, 8'h01);
    pulse(3'h1, 16'h1234);
    pulse(3'h6, 16'h1234);
    host_model_inst.rd(ADDR_STATUS, d);
    chk(d, 8'h9f);
    host_model_inst.rd(ADDR_OUT_X_LO, d);
    chk(d, 8'h34);
    host_model_inst.rd(ADDR_STATUS, d);
    chk(d, 8'h06);
    host_model_inst.wr(ADDR_FMT_CTRL, 8'h40);
    host_model_inst.rd(ADDR_OUT_X_LO, d);
    chk(d, 8'h12);
    host_model_inst.wr(ADDR_FMT_CTRL, 8'h80);
    host_model_inst.rd(ADDR_OUT_X_LO, d);
    pulse(3'h1, 16'habcd);
    host_model_inst.rd(ADDR_OUT_X_LO + 8'h01, d);
    chk(d, 8'h12);
    host_model_inst.wr(ADDR_FMT_CTRL, 8'h00);
    pulse(3'h1, 16'habcd);
    host_model_inst.rd(ADDR_OUT_X_LO + 8'h01, d);
    chk(d, 8'hab);
    $display("test samples done");
    @(posedge clock);
    filtered_output_select <= 1'b1;
    host_model_inst.rd(ADDR_FILTER_ZERO, d);
    host_model_inst.rd(ADDR_OUT_X_LO, d);
    chk(d, 8'h00);
    host_model_inst.rd(ADDR_OUT_X_LO + 8'h01, d);
    chk(d, 8'h00);
    @(posedge clock);
    {hpf_mode_field, hpf_on_irq1} <= {HPF_MODE_REF, 1'b1};
    host_model_inst.rd(ADDR_FILTER_ZERO, d);
    {hpf_mode_field, hpf_on_irq1, filtered_output_select} <= 4'h0;
    $display("test filter done");
    // Latched request per pad, cleared by source read
    for (int p = 0; p < 2; p++)
    begin
      host_model_inst.wr(ADDR_PAD_CTRL, p ? 8'h20 : 8'h04);
      @(posedge clock);
      irq1_events <= p ? 6'h00 : 6'h02;
      irq2_events <= p ? 6'h02 : 6'h00;
      @(posedge clock);
      {irq1_events, irq2_events} <= 12'h000;
      repeat (4) @(posedge clock);
      chk({7'h00, p ? irq2_pad_o : irq1_pad_o}, 8'h01);
      host_model_inst.rd(p ? ADDR_IRQ2_SRC : ADDR_IRQ1_SRC, d);
      chk(d, 8'h42);
      repeat (3) @(posedge clock);
      chk({7'h00, p ? irq2_pad_o : irq1_pad_o}, 8'h00);
    end
    $display("test latch done");
    @(posedge clock);
    power_mode_field <= PM_LP_FIRST;
    host_model_inst.wr(ADDR_WAKE_CTRL, 8'h03);
    repeat (3) @(posedge clock);
    chk({6'h00, run_low_power, run_normal}, 8'h02);
    chk({5'h00, low_power_rate}, 8'h02);
    irq1_events <= 6'h01;
    @(posedge clock);
    irq1_events <= 6'h00;
    repeat (4) @(posedge clock);
    chk({6'h00, run_low_power, run_normal}, 8'h01);
    $display("test wake done");
    print_verdict();
  end
endmodule // tb
